// *** logic/regulator_pkg.sv ***
// constants, types and register map of the regulator start-up sequencer
// assumes one 25 MHz clock shared by every module of the block
package regulator_pkg;

	localparam logic [7:0] OFS_TARGET_MSB = 8'h12;
	localparam logic [7:0] OFS_TARGET_LSB = 8'h13;
	localparam logic [7:0] OFS_RAMP_CTRL = 8'h14;
	localparam logic [7:0] OFS_BUS_LEVEL = 8'h1A;
	localparam logic [7:0] OFS_RAMP_DOWN = 8'h1C;
	localparam logic [7:0] OFS_ADDR_ROOT = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h21;

	localparam int BIT_TARGET_MSB = 0;
	localparam int BIT_RAMP_FAST = 3;
	localparam int BIT_DOWN_REQUEST = 2;
	localparam int BIT_BUS_LEVEL = 1;
	localparam int BIT_DOWN_ALLOW = 3;

	localparam logic [7:0] RST_ADDR_ROOT = 8'h08;
	localparam logic [8:0] RST_TARGET = 9'h000;

	localparam int CLK_FREQ_KHZ = 25000;
	localparam int STEP_TIME_NS = 1000;
	localparam int STEP_CYCLES = STEP_TIME_NS * CLK_FREQ_KHZ / 1000000;
	localparam int FIRST_PULSE_NS = 30;
	localparam int FIRST_PULSE_RAW = (FIRST_PULSE_NS * CLK_FREQ_KHZ + 999999) / 1000000;
	localparam int FIRST_PULSE_CYCLES = (FIRST_PULSE_RAW < 1) ? 1 : FIRST_PULSE_RAW;

	// reference in half-millivolt units: 0.5 mV/us is one unit per step
	localparam int REF_W = 13;
	localparam int REF_ORIGIN = 800;
	localparam int UNITS_PER_CODE = 10;
	localparam int STEP_SLOW = 1;
	localparam int STEP_FAST = 2;

	localparam int NVM_WORDS = 6;
	localparam int NVM_AW = 3;

	localparam int SY_BIAS = 0;
	localparam int SY_EN = 1;
	localparam int SY_REF_FB = 2;
	localparam int SY_OC = 3;
	localparam int SY_OV = 4;
	localparam int SY_STRAP = 5;
	localparam int SY_W = 8;

	typedef enum logic [2:0] {
		ST_BIAS_WAIT = 3'b000,
		ST_LOAD = 3'b001,
		ST_STRAP = 3'b010,
		ST_IDLE = 3'b011,
		ST_PREBIAS = 3'b100,
		ST_FIRST = 3'b101,
		ST_RUN = 3'b110,
		ST_STOPPED = 3'b111
	} state_e;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_s;

	typedef struct packed {
		logic [8:0] target;
		logic ramp_fast;
		logic down_request;
		logic bus_level;
		logic down_allow;
		logic [7:0] root;
	} config_s;

endpackage

// *** logic/nvm_loader.sv ***
// copies the non-volatile words into the working registers after reset
// assumes memory data is valid one clock after its address
`timescale 1ns/100ps
`default_nettype none

module nvm_loader
	import regulator_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	output logic [NVM_AW-1:0] nvm_addr,
	input wire logic [7:0] nvm_data,
	output reg_write_s load,
	output logic done
);

	typedef struct packed {
		logic busy;
		logic phase;
		logic [NVM_AW-1:0] idx;
		reg_write_s load;
		logic done;
	} loader_s;

	loader_s cur, next_cur;

	function automatic logic [7:0] word_offset(input logic [NVM_AW-1:0] i);
		unique case (i)
			3'h0: word_offset = OFS_TARGET_MSB;
			3'h1: word_offset = OFS_TARGET_LSB;
			3'h2: word_offset = OFS_RAMP_CTRL;
			3'h3: word_offset = OFS_BUS_LEVEL;
			3'h4: word_offset = OFS_RAMP_DOWN;
			default: word_offset = OFS_ADDR_ROOT;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	always_comb begin
		next_cur = cur;
		next_cur.load.wr = 1'b0;
		next_cur.done = 1'b0;
		if (start) begin
			next_cur.busy = 1'b1;
			next_cur.phase = 1'b0;
			next_cur.idx = '0;
		end else if (cur.busy) begin
			next_cur.phase = ~cur.phase;
			if (cur.phase) begin
				next_cur.load = '{wr: 1'b1, addr: word_offset(cur.idx), data: nvm_data};
				next_cur.idx = cur.idx + 3'h1;
				if (cur.idx == NVM_AW'(NVM_WORDS - 1)) begin
					next_cur.busy = 1'b0;
					next_cur.done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign nvm_addr = cur.idx;
	assign load = cur.load;
	assign done = cur.done;

endmodule

`default_nettype wire

// *** logic/ramp_generator.sv ***
// digital ramp reference, stepped once per microsecond tick
// assumes the caller holds clear whenever the converter must sit at zero
`timescale 1ns/100ps
`default_nettype none

module ramp_generator
	import regulator_pkg::*;
#(
	parameter int TICK_CYCLES = STEP_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic up,
	input wire logic down,
	input wire logic fast,
	input wire logic [REF_W-1:0] target,
	output logic [REF_W-1:0] ref_level,
	output logic at_target,
	output logic at_zero
);

	// divider is eight bits wide and needs at least one idle count
	if (TICK_CYCLES < 2 || TICK_CYCLES > 255) begin : g_tick_check
		$error("TICK_CYCLES out of range");
	end

	typedef struct packed {
		logic [7:0] div;
		logic [REF_W-1:0] level;
	} ramp_s;

	ramp_s cur, next_cur;
	logic tick;
	logic [REF_W-1:0] step;

	////////////////////////////////////////////////////////////////
	always_comb begin
		next_cur = cur;
		tick = (cur.div == 8'(TICK_CYCLES - 1));
		step = fast ? REF_W'(STEP_FAST) : REF_W'(STEP_SLOW);
		next_cur.div = tick ? 8'h00 : cur.div + 8'h01;
		if (clear) begin
			next_cur.level = '0;
			next_cur.div = 8'h00;
		end else if (tick && down) begin
			next_cur.level = (cur.level <= step) ? '0 : cur.level - step;
		end else if (tick && up) begin
			if (cur.level + step >= target) begin
				next_cur.level = target;
			end else begin
				next_cur.level = cur.level + step;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign ref_level = cur.level;
	assign at_target = (cur.level == target);
	assign at_zero = (cur.level == '0);

endmodule

`default_nettype wire

// *** logic/regulator_startup_sequencer.sv ***
// start-up, shut-down and addressing sequencer of a point-of-load regulator
// assumes a serial slave engine drives the register port on the same clock,
// and analogue comparators supply the fault, feedback and strap levels
//
// Function
// - bias valid leaves reset, loads memory into registers, finds address offset.
// - register access opens only after bias, load, init and offset; enable not needed.
// - register 0x1A bit 1 picks bus signalling range; zero is low range.
// - reference ramps only after initialisation and with enable asserted.
// - register 0x14 bit 3 picks 0.5 or 1 mV per us ramp.
// - nine-bit target code, 5 mV steps above 0.4 V origin.
// - ramp starts with minimum-width high-side pulses, then on-time grows.
// - over-current and over-voltage guards act during the ramp too.
// - pre-charged output keeps drivers off until reference exceeds feedback; high side first.
// - power good stays low until the reference reaches target in run, after pre-bias and the first high-side pulse.
// - enable low turns drivers off and zeroes the reference at once.
// - request and allow both set: reference falls at ramp rate, drivers off at zero.
// - ramp-down request and allow both reset to zero.
// - eight-bit address root loaded from memory, default 0x08.
// - strap offset zero to seven is added to the address root.
// - strap sampled once at start-up, eight ranges map to offsets.
`timescale 1ns/100ps
`default_nettype none

module regulator_startup_sequencer
	import regulator_pkg::*;
#(
	parameter int TICK_CYCLES = STEP_CYCLES
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic BIAS_LOCKOUT_CLEAR,
	input wire logic EN,
	input wire logic [2:0] ADDR_STRAP,
	input wire logic REF_ABOVE_FEEDBACK,
	input wire logic OVERCURRENT_GUARD,
	input wire logic OVERVOLTAGE_GUARD,
	output logic [NVM_AW-1:0] NVM_ADDR,
	input wire logic [7:0] NVM_DATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic BUS_READY,
	output logic BUS_LEVEL_HIGH,
	output logic [7:0] DEV_ADDR,
	output logic [REF_W-1:0] REF_DAC,
	output logic HIGH_SIDE_GATE_DRIVE,
	output logic LOW_SIDE_GATE_DRIVE,
	output logic MIN_ON_MODE,
	output logic POWER_OK_OUTPUT
);

	typedef struct packed {
		// pin and comparator levels, two flops deep
		logic [SY_W-1:0] sync1;
		logic [SY_W-1:0] sync2;
		state_e state;
		config_s cfg;
		logic [2:0] offset;
		logic fault;
		logic ready;
		logic pg;
		logic hs;
		logic ls;
		logic min_on;
		logic load_start;
		logic [2:0] first_cnt;
		logic [7:0] dev_addr;
		logic [7:0] rdata;
	} seq_s;

	localparam config_s RST_CFG = '{target: RST_TARGET, ramp_fast: 1'b0, down_request: 1'b0,
		bus_level: 1'b0, down_allow: 1'b0, root: RST_ADDR_ROOT};

	seq_s cur, next_cur;
	reg_write_s load;
	logic load_done;
	logic [REF_W-1:0] ref_level;
	logic [REF_W-1:0] target_units;
	logic at_target;
	logic at_zero;
	logic active;
	logic down_mode;
	logic bias;
	logic en;
	logic fault_in;

	// divider is eight bits wide and needs at least one idle count
	if (TICK_CYCLES < 2 || TICK_CYCLES > 255) begin : g_tick_check
		$error("TICK_CYCLES out of range");
	end
	// first-pulse counter is three bits wide
	if (FIRST_PULSE_CYCLES < 1 || FIRST_PULSE_CYCLES > 8) begin : g_pulse_check
		$error("FIRST_PULSE_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////
	// shared write decode: memory load and host writes land alike
	function automatic config_s apply_write(input config_s c, input logic [7:0] a, input logic [7:0] d);
		apply_write = c;
		unique case (a)
			OFS_TARGET_MSB: apply_write.target[8] = d[BIT_TARGET_MSB];
			OFS_TARGET_LSB: apply_write.target[7:0] = d;
			OFS_RAMP_CTRL: begin
				apply_write.ramp_fast = d[BIT_RAMP_FAST];
				apply_write.down_request = d[BIT_DOWN_REQUEST];
			end
			OFS_BUS_LEVEL: apply_write.bus_level = d[BIT_BUS_LEVEL];
			OFS_RAMP_DOWN: apply_write.down_allow = d[BIT_DOWN_ALLOW];
			OFS_ADDR_ROOT: apply_write.root = d;
			default: apply_write = c;
		endcase
	endfunction

	function automatic logic [7:0] read_reg(input seq_s s, input logic [7:0] a);
		read_reg = 8'h00;
		unique case (a)
			OFS_TARGET_MSB: read_reg[BIT_TARGET_MSB] = s.cfg.target[8];
			OFS_TARGET_LSB: read_reg = s.cfg.target[7:0];
			OFS_RAMP_CTRL: begin
				read_reg[BIT_RAMP_FAST] = s.cfg.ramp_fast;
				read_reg[BIT_DOWN_REQUEST] = s.cfg.down_request;
			end
			OFS_BUS_LEVEL: read_reg[BIT_BUS_LEVEL] = s.cfg.bus_level;
			OFS_RAMP_DOWN: read_reg[BIT_DOWN_ALLOW] = s.cfg.down_allow;
			OFS_ADDR_ROOT: read_reg = s.cfg.root;
			OFS_STATUS: read_reg = {s.state, s.offset, s.fault, s.pg};
			default: read_reg = 8'h00;
		endcase
	endfunction

	// states in which the ramp runs and the guards are watched
	function automatic logic ramp_state(input state_e s);
		ramp_state = (s == ST_PREBIAS) || (s == ST_FIRST) || (s == ST_RUN);
	endfunction

	////////////////////////////////////////////////////////////////
	nvm_loader u_loader (
		.clk(MCLK),
		.rst_n(RST_N),
		.start(cur.load_start),
		.nvm_addr(NVM_ADDR),
		.nvm_data(NVM_DATA),
		.load(load),
		.done(load_done)
	);

	// ramp held cleared whenever it may not run
	ramp_generator #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_ramp (
		.clk(MCLK),
		.rst_n(RST_N),
		.clear(~active),
		.up(active & ~down_mode),
		.down(active & down_mode),
		.fast(cur.cfg.ramp_fast),
		.target(target_units),
		.ref_level(ref_level),
		.at_target(at_target),
		.at_zero(at_zero)
	);

	////////////////////////////////////////////////////////////////
	always_comb begin
		bias = cur.sync2[SY_BIAS];
		en = cur.sync2[SY_EN];
		fault_in = cur.sync2[SY_OC] | cur.sync2[SY_OV];
		// origin plus code steps, kept in half-millivolt units
		target_units = REF_W'(REF_ORIGIN) + REF_W'(cur.cfg.target) * REF_W'(UNITS_PER_CODE);
		down_mode = cur.cfg.down_request & cur.cfg.down_allow;
		// enable and faults cut the ramp in the same cycle they are seen
		active = en & ~fault_in & ramp_state(cur.state);

		next_cur = cur;
		// raw levels only enter the first flop; logic reads the second
		next_cur.sync1 = {ADDR_STRAP, OVERVOLTAGE_GUARD, OVERCURRENT_GUARD, REF_ABOVE_FEEDBACK, EN,
			BIAS_LOCKOUT_CLEAR};
		next_cur.sync2 = cur.sync1;
		next_cur.load_start = 1'b0;

		// memory load wins; the host is closed then anyway
		if (load.wr) begin
			next_cur.cfg = apply_write(cur.cfg, load.addr, load.data);
		end else if (REG_WR && cur.ready) begin
			next_cur.cfg = apply_write(cur.cfg, REG_ADDR, REG_WDATA);
		end
		if (REG_RD && cur.ready) begin
			next_cur.rdata = read_reg(cur, REG_ADDR);
		end

		unique case (cur.state)
			ST_BIAS_WAIT: begin
				if (bias) begin
					next_cur.load_start = 1'b1;
					next_cur.state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (load_done) begin
					next_cur.state = ST_STRAP;
				end
			end
			ST_STRAP: begin
				// strap read once; later strap changes are ignored
				next_cur.offset = cur.sync2[SY_STRAP+:3];
				next_cur.state = ST_IDLE;
			end
			ST_IDLE: begin
				if (en) begin
					next_cur.state = down_mode ? ST_STOPPED : ST_PREBIAS;
				end
			end
			ST_PREBIAS: begin
				if (cur.sync2[SY_REF_FB]) begin
					next_cur.state = ST_FIRST;
					next_cur.first_cnt = 3'(FIRST_PULSE_CYCLES - 1);
				end
			end
			ST_FIRST: begin
				// high side alone for one minimum pulse before the low side joins
				if (cur.first_cnt == 3'h0) begin
					next_cur.state = ST_RUN;
				end else begin
					next_cur.first_cnt = cur.first_cnt - 3'h1;
				end
			end
			ST_RUN: begin
				if (down_mode && at_zero) begin
					next_cur.state = ST_STOPPED;
				end
			end
			ST_STOPPED: begin
				// a latched fault waits for enable low; a soft stop waits for request clear
				if (!cur.fault && !down_mode) begin
					next_cur.state = ST_PREBIAS;
				end
			end
		endcase

		// guards watched during the ramp as well, not only at target
		if (fault_in && ramp_state(cur.state)) begin
			next_cur.fault = 1'b1;
			next_cur.state = ST_STOPPED;
		end
		if (!en && cur.state >= ST_PREBIAS) begin
			next_cur.state = ST_IDLE;
			next_cur.fault = 1'b0;
		end
		// bias loss undoes state, fault and registers; a load in progress runs on, but its writes are overridden while bias is low; the strap offset is kept
		if (!bias) begin
			next_cur.state = ST_BIAS_WAIT;
			next_cur.fault = 1'b0;
			next_cur.cfg = RST_CFG;
		end

		// outputs follow the next state so each one stands in a flop
		next_cur.ready = (next_cur.state >= ST_IDLE);
		next_cur.hs = (next_cur.state == ST_FIRST || next_cur.state == ST_RUN);
		next_cur.ls = (next_cur.state == ST_RUN);
		next_cur.min_on = (next_cur.state == ST_FIRST) ||
			(next_cur.state == ST_RUN && !at_target && !down_mode);
		// power good only in run at target, never during a soft stop
		next_cur.pg = (next_cur.state == ST_RUN) && at_target && !down_mode;
		// built from next values so the address is right as the bus opens
		next_cur.dev_addr = next_cur.cfg.root + {5'b00000, next_cur.offset};
	end

	// reset values match the register defaults
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cur <= '{sync1: '0, sync2: '0, state: ST_BIAS_WAIT, cfg: RST_CFG, offset: 3'h0, fault: 1'b0,
				ready: 1'b0, pg: 1'b0, hs: 1'b0, ls: 1'b0, min_on: 1'b0, load_start: 1'b0,
				first_cnt: 3'h0, dev_addr: RST_ADDR_ROOT, rdata: 8'h00};
		end else begin
			cur <= next_cur;
		end
	end

	// every output below is a flop of the state struct except REF_DAC, which is the ramp generator's level flop
	assign REG_RDATA = cur.rdata;
	assign BUS_READY = cur.ready;
	assign BUS_LEVEL_HIGH = cur.cfg.bus_level;
	assign DEV_ADDR = cur.dev_addr;
	assign REF_DAC = ref_level;
	assign HIGH_SIDE_GATE_DRIVE = cur.hs;
	assign LOW_SIDE_GATE_DRIVE = cur.ls;
	assign MIN_ON_MODE = cur.min_on;
	assign POWER_OK_OUTPUT = cur.pg;

endmodule

`default_nettype wire

// *** verif/regulator_startup_sequencer_asserts.sv ***
// port assertions of the start-up sequencer
// assumes binding to the sequencer top, one clock domain, reset active low
`timescale 1ns/100ps
`default_nettype none

module regulator_startup_sequencer_asserts
	import regulator_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic BIAS_LOCKOUT_CLEAR,
	input wire logic EN,
	input wire logic OVERCURRENT_GUARD,
	input wire logic BUS_READY,
	input wire logic [REF_W-1:0] REF_DAC,
	input wire logic HIGH_SIDE_GATE_DRIVE,
	input wire logic LOW_SIDE_GATE_DRIVE,
	input wire logic MIN_ON_MODE,
	input wire logic POWER_OK_OUTPUT
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	////////////////////////////////////////////////////////////////////////
	// margins cover the two-flop input synchronisers
	chk_bias_closes_bus: assert property (!BIAS_LOCKOUT_CLEAR [*5] |-> !BUS_READY)
		else $error("bus open without bias");
	chk_en_drops_drive: assert property (!EN [*5] |-> !HIGH_SIDE_GATE_DRIVE && !LOW_SIDE_GATE_DRIVE)
		else $error("drivers on with enable low");
	chk_en_zero_ref: assert property (!EN [*6] |-> REF_DAC == 13'h0000)
		else $error("reference not zero with enable low");
	chk_ramp_step_size: assert property (REF_DAC > $past(REF_DAC) |-> REF_DAC - $past(REF_DAC) <= 13'h0002)
		else $error("reference step too large");
	chk_hs_pulse_first: assert property ($rose(HIGH_SIDE_GATE_DRIVE) |->
		MIN_ON_MODE && !LOW_SIDE_GATE_DRIVE ##1 LOW_SIDE_GATE_DRIVE)
		else $error("first pulse order wrong");
	chk_pg_in_run: assert property ($rose(POWER_OK_OUTPUT) |->
		HIGH_SIDE_GATE_DRIVE && LOW_SIDE_GATE_DRIVE && !MIN_ON_MODE)
		else $error("power good before switching");
	chk_fault_stops_drive: assert property (OVERCURRENT_GUARD [*5] |-> !HIGH_SIDE_GATE_DRIVE && !POWER_OK_OUTPUT)
		else $error("drivers on during fault");
	chk_min_on_ends: assert property ($fell(MIN_ON_MODE) && LOW_SIDE_GATE_DRIVE |=> POWER_OK_OUTPUT)
		else $error("power good missing at target");
endmodule

bind regulator_startup_sequencer regulator_startup_sequencer_asserts chk (.MCLK, .RST_N, .BIAS_LOCKOUT_CLEAR, .EN,
	.OVERCURRENT_GUARD, .BUS_READY, .REF_DAC, .HIGH_SIDE_GATE_DRIVE, .LOW_SIDE_GATE_DRIVE, .MIN_ON_MODE,
	.POWER_OK_OUTPUT);

`default_nettype wire

// *** verif/regulator_memory_model.sv ***
// non-volatile memory image read by the loader
// assumes word order target msb, target lsb, ramp, bus level, ramp down, root
`timescale 1ns/100ps
`default_nettype none

module regulator_memory_model
	import regulator_pkg::*;
#(
	parameter logic [7:0] ROOT = 8'h30
) (
	input wire logic clk,
	input wire logic [NVM_AW-1:0] addr,
	output logic [7:0] data
);
	logic [7:0] image [NVM_WORDS];

	// code 5 stays well inside the trim band
	initial begin
		image = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, ROOT};
	end

	// unused words toggle so a stray read never looks valid
	always_ff @(posedge clk) begin
		if (addr < NVM_WORDS) begin
			data <= image[addr];
		end else begin
			data <= ~data;
		end
	end
endmodule

`default_nettype wire

// *** verif/test_regulator_startup_sequencer.sv ***
// self-checking bench of the start-up sequencer
// assumes the memory model as far side and a 40 ns clock
`timescale 1ns/100ps
`default_nettype none

module test_regulator_startup_sequencer
	import regulator_pkg::*;
;
	localparam int TICK = 4;
	localparam logic [7:0] ROOT = 8'h30;
	logic mclk, rst_n, bias, en, ref_above, oc, ov, reg_wr, reg_rd, bus_ready, bus_level_high, hs, ls, min_on, pg;
	logic [2:0] strap, nvm_addr;
	logic [7:0] nvm_data, reg_addr, reg_wdata, reg_rdata, dev_addr;
	logic [REF_W-1:0] ref_dac;
	logic [3:0] flags;
	logic [7:0] ra [7] = '{OFS_TARGET_MSB, OFS_TARGET_LSB, OFS_RAMP_CTRL, OFS_BUS_LEVEL, OFS_RAMP_DOWN,
		OFS_ADDR_ROOT, 8'h40};
	logic [7:0] re [7] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, ROOT, 8'h00};
	int n_fail;
	int n_checks;

	assign flags = {pg, min_on, hs, bus_ready};

	regulator_startup_sequencer #(.TICK_CYCLES(TICK)) uut (.MCLK(mclk), .RST_N(rst_n), .BIAS_LOCKOUT_CLEAR(bias),
		.EN(en), .ADDR_STRAP(strap), .REF_ABOVE_FEEDBACK(ref_above), .OVERCURRENT_GUARD(oc),
		.OVERVOLTAGE_GUARD(ov), .NVM_ADDR(nvm_addr), .NVM_DATA(nvm_data), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .BUS_READY(bus_ready),
		.BUS_LEVEL_HIGH(bus_level_high), .DEV_ADDR(dev_addr), .REF_DAC(ref_dac), .HIGH_SIDE_GATE_DRIVE(hs),
		.LOW_SIDE_GATE_DRIVE(ls), .MIN_ON_MODE(min_on), .POWER_OK_OUTPUT(pg));

	regulator_memory_model #(.ROOT(ROOT)) mem (.clk(mclk), .addr(nvm_addr), .data(nvm_data));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	// inputs move 1 ns after the edge, clear of sampling
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic summarize;
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic give_up;
		n_fail++;
		summarize();
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// an edge passes after each strobe so strobes never touch twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		tick(1);
		reg_wr = 1'b0;
		tick(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd = 1'b1;
		reg_addr = a;
		tick(1);
		reg_rd = 1'b0;
		tick(1);
		check(reg_rdata, e);
	endtask

	task automatic wait_flag(input int k, input logic v, input int lim);
		for (int i = 0; i < lim && flags[k] !== v; i++)
			tick(1);
		if (flags[k] !== v)
			give_up();
	endtask

	task automatic wait_ref(input logic [REF_W-1:0] v, input int lim);
		for (int i = 0; i < lim && ref_dac !== v; i++)
			tick(1);
		if (ref_dac !== v)
			give_up();
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		n_fail = 0;
		n_checks = 0;
		rst_n = 1'b0;
		{bias, en, ref_above, oc, ov, reg_wr, reg_rd} = 7'h00;
		strap = 3'h5;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		tick(4);
		rst_n = 1'b1;
		check(dev_addr, 8'h08);
		wr(OFS_BUS_LEVEL, 8'h02);
		check(bus_level_high, 1'b0);
		rd(OFS_ADDR_ROOT, 8'h00);
		bias = 1'b1;
		wait_flag(0, 1'b1, 100);
		check(dev_addr, ROOT + 8'h05);
		strap = 3'h2;
		tick(6);
		check(dev_addr, ROOT + 8'h05);
		foreach (ra[i])
			rd(ra[i], re[i]);
		wr(OFS_BUS_LEVEL, 8'h02);
		check(bus_level_high, 1'b1);
		wr(OFS_BUS_LEVEL, 8'h00);
		check(bus_level_high, 1'b0);
		// allow bit set only while not switching
		wr(OFS_RAMP_DOWN, 8'h08);
		// slow ramp into a pre-charged output
		en = 1'b1;
		wait_ref(13'h0064, 1000);
		check(hs, 1'b0);
		tick(10 * TICK);
		check(ref_dac, 13'h006E);
		ref_above = 1'b1;
		wait_flag(1, 1'b1, 20);
		check(min_on, 1'b1);
		wait_flag(3, 1'b1, 4000);
		check(ref_dac, 13'h0352);
		// controlled ramp-down at the fast rate, then restart
		wr(OFS_RAMP_CTRL, 8'h0C);
		wait_ref(13'h0190, 3000);
		check(hs, 1'b1);
		wait_flag(1, 1'b0, 2000);
		check(ref_dac, 13'h0000);
		wr(OFS_RAMP_CTRL, 8'h08);
		wait_ref(13'h0064, 1000);
		tick(10 * TICK);
		check(ref_dac, 13'h0078);
		// fault during the ramp, then hard shut-down
		oc = 1'b1;
		tick(6);
		check({hs, ls, pg}, 3'h0);
		en = 1'b0;
		tick(6);
		check(ref_dac, 13'h0000);
		oc = 1'b0;
		// enable dropped in mid-ramp clears drivers and reference at once
		en = 1'b1;
		wait_ref(13'h0064, 1000);
		en = 1'b0;
		tick(3);
		check({hs, ls, ref_dac}, 15'h0000);
		bias = 1'b0;
		wait_flag(0, 1'b0, 20);
		summarize();
	end
endmodule

`default_nettype wire
